// file: rtl/mpu_regs_pkg.sv
// Purpose: Shared constants and types of the memory protection register block
// Assumes: Eight regions, 32-bit core address space
// Notes: Offsets are byte offsets from the block's base
package mpu_regs_pkg;

  // ****************************************
  // Sizes
  // ****************************************
  localparam int REGION_COUNT = 8;
  localparam int IDX_W = 3;

  // ****************************************
  // Register offsets and reset values
  // ****************************************
  localparam logic [7:0] OFS_CONTROL = 8'h04;
  localparam logic [7:0] OFS_SELECT = 8'h08;
  localparam logic [7:0] OFS_BASE = 8'h0c;
  localparam logic [7:0] OFS_ATTR = 8'h10;
  localparam logic [2:0] CONTROL_RESET = 3'h0;
  localparam logic [7:0] SELECT_RESET = 8'h00;
  localparam logic [26:0] BASE_RESET = 27'h0000000;
  localparam logic [31:0] ATTR_RESET = 32'h00000000;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int CTRL_ENABLE_BIT = 0;
  localparam int CTRL_HANDLER_BIT = 1;
  localparam int CTRL_BG_BIT = 2;
  localparam int BASE_VALID_BIT = 4;
  localparam int BASE_REGION_LSB = 0;
  localparam int BASE_ADDR_LSB = 5;
  localparam int ATTR_XN_BIT = 28;
  localparam int ATTR_AP_LSB = 24;
  localparam int ATTR_TEX_LSB = 19;
  localparam int ATTR_SRD_LSB = 8;
  localparam int ATTR_SIZE_LSB = 1;
  localparam int ATTR_EN_BIT = 0;
  localparam int ATTR_MEM_LSB = 16;
  localparam logic [31:0] ATTR_WRITE_MASK = 32'h1f3fff3f;

  // ****************************************
  // Sizes, permissions, address map
  // ****************************************
  localparam logic [4:0] SIZE_FULL_MAP = 5'h1f;
  localparam logic [4:0] SIZE_SUBREGION_MIN = 5'h07;
  localparam logic [2:0] AP_NONE = 3'h0;
  localparam logic [2:0] AP_PRIV_RW = 3'h1;
  localparam logic [2:0] AP_USER_RO = 3'h2;
  localparam logic [2:0] AP_FULL = 3'h3;
  localparam logic [2:0] AP_PRIV_RO = 3'h5;
  localparam logic [2:0] AP_RO_ALL = 3'h6;
  localparam logic [2:0] AP_RO_ALL_B = 3'h7;
  localparam logic [31:0] SCS_FIRST = 32'he000e000;
  localparam logic [31:0] SCS_LAST = 32'he000efff;
  localparam logic [5:0] DEFAULT_MEM_ATTR = 6'h00;

  typedef enum logic [0:0] {
    PORT_IDLE = 1'b0,
    PORT_WAIT = 1'b1
  } port_state_t;

endpackage

// file: rtl/region_if.sv
// Purpose: Carries region table writes, reads and contents between modules
// Assumes: One writer per cycle
// Notes: Flat entry arrays feed the parallel address check
interface region_if;
  import mpu_regs_pkg::*;
  logic [IDX_W-1:0] wr_idx;
  logic wr_base_en;
  logic [26:0] wr_base;
  logic [3:0] wr_attr_be;
  logic [31:0] wr_attr;
  logic [IDX_W-1:0] rd_idx;
  logic [26:0] rd_base;
  logic [31:0] rd_attr;
  logic [26:0] base [REGION_COUNT];
  logic [31:0] attr [REGION_COUNT];

  modport store (
    input wr_idx, wr_base_en, wr_base, wr_attr_be, wr_attr, rd_idx,
    output rd_base, rd_attr, base, attr
  );
  modport user (
    output wr_idx, wr_base_en, wr_base, wr_attr_be, wr_attr, rd_idx,
    input rd_base, rd_attr, base, attr
  );
endinterface

// file: rtl/region_store.sv
// Purpose: Region table: base and attribute/size word per region
// Assumes: Writes already decoded by the register port
// Notes: Read data is registered; reserved attribute bits never store
module region_store
  import mpu_regs_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  region_if.store rif
);

  // ****************************************
  // Entries
  // ****************************************
  for (genvar i = 0; i < REGION_COUNT; i++) begin : g_entry
    logic [26:0] base_q;
    logic [31:0] attr_q;
    logic [26:0] next_base;
    logic [31:0] next_attr;
    logic sel;

    assign sel = (rif.wr_idx == IDX_W'(i));

    always_comb begin
      next_base = base_q;
      next_attr = attr_q;
      if (sel && rif.wr_base_en) begin
        next_base = rif.wr_base;
      end
      for (int b = 0; b < 4; b++) begin
        // Byte lanes let software touch one halfword of attributes
        if (sel && rif.wr_attr_be[b]) begin
          next_attr[8*b +: 8] = rif.wr_attr[8*b +: 8] & ATTR_WRITE_MASK[8*b +: 8];
        end
      end
    end

    always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
        base_q <= BASE_RESET;
        attr_q <= ATTR_RESET;
      end else begin
        base_q <= next_base;
        attr_q <= next_attr;
      end
    end

    assign rif.base[i] = base_q;
    assign rif.attr[i] = attr_q;
  end

  // ****************************************
  // Read port
  // ****************************************
  logic [26:0] next_rd_base;
  logic [31:0] next_rd_attr;

  always_comb begin
    next_rd_base = rif.base[rif.rd_idx];
    next_rd_attr = rif.attr[rif.rd_idx];
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rif.rd_base <= BASE_RESET;
      rif.rd_attr <= ATTR_RESET;
    end else begin
      rif.rd_base <= next_rd_base;
      rif.rd_attr <= next_rd_attr;
    end
  end

endmodule

// file: rtl/memory_protection_unit_regs.sv
// Purpose: Protection unit control, region programming and access check
// Assumes: Core drives one check request per cycle, synchronous inputs
// Notes: Check answer one cycle after request; register read answer two cycles
// Notes on behaviour
// - Unit disabled: default map applies to privileged and unprivileged accesses.
// - Background bit set: privileged miss uses default map, unprivileged miss faults.
// - Background bit clear: any non-vector access outside system control space missing all enabled regions faults.
// - Background acts as region -1; ignored while the unit is disabled.
// - System control space is always execute-never and strongly ordered.
// - Enabled unit always permits system control space data accesses and vector table accesses.
// - Priority -1/-2 handlers bypass protection unless handler protection bit set.
// - Region select names the entry that base and attribute registers reach.
// - Base write with valid bit copies region field into select, stores there.
// - Base write without valid bit keeps select and stores to selected region.
// - Base read shows valid as zero and region field from select.
// - Base field is bits 31:N; bits N-1:5 read as zero.
// - Size 4 GB region covers whole map from address zero.
// - Attribute/size register takes word or halfword writes by byte lanes.
// - Execute-never bit 28 blocks instruction fetches from the region.
// - Attribute fields stored at their positions; bits 23:22 read zero.
// - Each subregion-disable bit set removes its subregion from a region of size 7 or more.
// - Region size is two to the power size plus one bytes.
// - Permission code decides read and write rights per privilege.
// - Lowest subregion bit is first eighth; disabled part falls to others.
module memory_protection_unit_regs
  import mpu_regs_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic reg_valid,
  input wire logic reg_write,
  input wire logic [7:0] reg_addr,
  input wire logic [3:0] reg_byte_en,
  input wire logic [31:0] reg_wdata,
  output logic reg_ready,
  output logic reg_rvalid,
  output logic [31:0] reg_rdata,
  input wire logic chk_valid,
  input wire logic [31:0] chk_addr,
  input wire logic chk_priv,
  input wire logic chk_write,
  input wire logic chk_fetch,
  input wire logic chk_vector,
  input wire logic chk_handler_neg,
  output logic chk_done,
  output logic chk_fault,
  output logic chk_strong,
  output logic [5:0] chk_mem_attr
);

  region_if rif ();

  region_store u_store (
    .clock(clock),
    .rst(rst),
    .rif(rif)
  );

  function automatic logic [31:0] size_mask(input logic [4:0] sz);
    if (sz == SIZE_FULL_MAP) begin
      size_mask = 32'h00000000;
    end else begin
      size_mask = 32'hffffffff << (6'(sz) + 6'h01);
    end
  endfunction

  function automatic logic perm_ok(input logic [2:0] ap, input logic priv, input logic wr);
    case (ap)
      AP_PRIV_RW: perm_ok = priv;
      AP_USER_RO: perm_ok = priv || !wr;
      AP_FULL: perm_ok = 1'b1;
      AP_PRIV_RO: perm_ok = priv && !wr;
      AP_RO_ALL, AP_RO_ALL_B: perm_ok = !wr;
      default: perm_ok = 1'b0;
    endcase
  endfunction

  // ****************************************
  // Register port
  // ****************************************
  port_state_t state, next_state;
  logic [2:0] ctrl, next_ctrl;
  logic [7:0] region_select, next_region_select;
  logic [7:0] pend_addr, next_pend_addr;
  logic [31:0] next_rdata;
  logic next_rvalid;
  logic take, wr_take;

  assign reg_ready = (state == PORT_IDLE);
  assign take = reg_valid && reg_ready;
  assign wr_take = take && reg_write;
  assign rif.rd_idx = region_select[IDX_W-1:0];

  always_comb begin
    next_state = state;
    next_ctrl = ctrl;
    next_region_select = region_select;
    next_pend_addr = pend_addr;
    next_rvalid = 1'b0;
    next_rdata = reg_rdata;
    rif.wr_idx = region_select[IDX_W-1:0];
    rif.wr_base_en = 1'b0;
    rif.wr_base = reg_wdata[31:BASE_ADDR_LSB];
    rif.wr_attr_be = 4'h0;
    rif.wr_attr = reg_wdata;
    case (state)
      PORT_IDLE: begin
        if (take && !reg_write) begin
          // Table read data lags select by one edge, so wait a cycle
          next_state = PORT_WAIT;
          next_pend_addr = reg_addr;
        end
        if (wr_take) begin
          case (reg_addr)
            OFS_CONTROL: next_ctrl = reg_wdata[2:0];
            OFS_SELECT: next_region_select = reg_wdata[7:0];
            OFS_BASE: begin
              rif.wr_base_en = 1'b1;
              if (reg_wdata[BASE_VALID_BIT]) begin
                next_region_select = {4'h0, reg_wdata[BASE_REGION_LSB +: 4]};
                rif.wr_idx = reg_wdata[BASE_REGION_LSB +: IDX_W];
              end
            end
            OFS_ATTR: rif.wr_attr_be = reg_byte_en;
            default: next_ctrl = ctrl;
          endcase
        end
      end
      PORT_WAIT: begin
        next_state = PORT_IDLE;
        next_rvalid = 1'b1;
        case (pend_addr)
          OFS_CONTROL: next_rdata = {29'h0, ctrl};
          OFS_SELECT: next_rdata = {24'h0, region_select};
          OFS_BASE: begin
            next_rdata = {rif.rd_base, 5'h00} & size_mask(rif.rd_attr[ATTR_SIZE_LSB +: 5]);
            next_rdata[3:0] = region_select[3:0];
          end
          OFS_ATTR: next_rdata = rif.rd_attr;
          default: next_rdata = 32'h00000000;
        endcase
      end
      default: next_state = PORT_IDLE;
    endcase
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state <= PORT_IDLE;
      ctrl <= CONTROL_RESET;
      region_select <= SELECT_RESET;
      pend_addr <= 8'h00;
      reg_rvalid <= 1'b0;
      reg_rdata <= 32'h00000000;
    end else begin
      state <= next_state;
      ctrl <= next_ctrl;
      region_select <= next_region_select;
      pend_addr <= next_pend_addr;
      reg_rvalid <= next_rvalid;
      reg_rdata <= next_rdata;
    end
  end

  // ****************************************
  // Region match
  // ****************************************
  logic [REGION_COUNT-1:0] region_hit;

  for (genvar i = 0; i < REGION_COUNT; i++) begin : g_hit
    logic [4:0] sz;
    logic [2:0] sub;
    logic in_range;
    assign sz = rif.attr[i][ATTR_SIZE_LSB +: 5];
    assign sub = 3'((chk_addr >> (sz - 5'd2)) & 32'h7);
    assign in_range = ((chk_addr ^ {rif.base[i], 5'h00}) & size_mask(sz)) == 32'h0;
    assign region_hit[i] = rif.attr[i][ATTR_EN_BIT] && in_range &&
      !((sz >= SIZE_SUBREGION_MIN) && rif.attr[i][ATTR_SRD_LSB + 32'(sub)]);
  end

  logic any_hit;
  logic [IDX_W-1:0] win_idx;
  logic [31:0] win_attr;

  always_comb begin
    any_hit = 1'b0;
    win_idx = '0;
    for (int i = 0; i < REGION_COUNT; i++) begin
      if (region_hit[i]) begin
        any_hit = 1'b1;
        win_idx = IDX_W'(i);
      end
    end
    win_attr = rif.attr[win_idx];
  end

  // ****************************************
  // Access decision
  // ****************************************
  logic in_scs, active;
  logic next_done, next_fault, next_strong;
  logic [5:0] next_mem_attr;

  assign in_scs = (chk_addr >= SCS_FIRST) && (chk_addr <= SCS_LAST);
  assign active = ctrl[CTRL_ENABLE_BIT] && !(chk_handler_neg && !ctrl[CTRL_HANDLER_BIT]);

  always_comb begin
    next_done = chk_valid;
    next_fault = 1'b0;
    next_strong = 1'b0;
    next_mem_attr = DEFAULT_MEM_ATTR;
    if (chk_valid) begin
      if (in_scs) begin
        next_fault = chk_fetch;
        next_strong = 1'b1;
      end else if (!active) begin
        next_fault = 1'b0;
      end else if (chk_vector) begin
        next_fault = 1'b0;
      end else if (any_hit) begin
        next_mem_attr = win_attr[ATTR_MEM_LSB +: 6];
        next_fault = !perm_ok(win_attr[ATTR_AP_LSB +: 3], chk_priv, chk_write) ||
          (chk_fetch && win_attr[ATTR_XN_BIT]);
      end else if (ctrl[CTRL_BG_BIT]) begin
        next_fault = !chk_priv;
      end else begin
        next_fault = 1'b1;
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      chk_done <= 1'b0;
      chk_fault <= 1'b0;
      chk_strong <= 1'b0;
      chk_mem_attr <= DEFAULT_MEM_ATTR;
    end else begin
      chk_done <= next_done;
      chk_fault <= next_fault;
      chk_strong <= next_strong;
      chk_mem_attr <= next_mem_attr;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  property p_disabled_no_fault;
    chk_valid && !ctrl[CTRL_ENABLE_BIT] && !in_scs |=> chk_done && !chk_fault;
  endproperty
  a_disabled_no_fault: assert property (p_disabled_no_fault) else $error("fault while unit off");

  property p_bg_priv_miss;
    chk_valid && active && ctrl[CTRL_BG_BIT] && !any_hit && !in_scs && !chk_vector
      |=> chk_fault == !$past(chk_priv);
  endproperty
  a_bg_priv_miss: assert property (p_bg_priv_miss) else $error("background miss wrong");

  property p_miss_faults;
    chk_valid && active && !ctrl[CTRL_BG_BIT] && !any_hit && !in_scs && !chk_vector
      |=> chk_fault;
  endproperty
  a_miss_faults: assert property (p_miss_faults) else $error("miss did not fault");

  property p_scs_rules;
    chk_valid && in_scs |=> chk_strong && (chk_fault == $past(chk_fetch));
  endproperty
  a_scs_rules: assert property (p_scs_rules) else $error("control space rule broken");

  property p_vector_allowed;
    chk_valid && chk_vector && !in_scs |=> !chk_fault;
  endproperty
  a_vector_allowed: assert property (p_vector_allowed) else $error("vector access faulted");

  property p_handler_bypass;
    chk_valid && chk_handler_neg && !ctrl[CTRL_HANDLER_BIT] && !in_scs |=> !chk_fault;
  endproperty
  a_handler_bypass: assert property (p_handler_bypass) else $error("handler not bypassed");

  property p_select_from_base;
    wr_take && reg_addr == OFS_BASE && reg_wdata[BASE_VALID_BIT]
      |=> region_select == {4'h0, $past(reg_wdata[3:0])};
  endproperty
  a_select_from_base: assert property (p_select_from_base) else $error("select not updated");

  property p_select_kept;
    wr_take && reg_addr == OFS_BASE && !reg_wdata[BASE_VALID_BIT] |=> $stable(region_select);
  endproperty
  a_select_kept: assert property (p_select_kept) else $error("select changed");

  property p_base_read;
    take && !reg_write && reg_addr == OFS_BASE
      |-> ##2 reg_rvalid && !reg_rdata[4] && reg_rdata[3:0] == region_select[3:0];
  endproperty
  a_base_read: assert property (p_base_read) else $error("base read wrong");

  property p_xn_fetch;
    chk_valid && active && any_hit && !in_scs && !chk_vector && chk_fetch &&
      win_attr[ATTR_XN_BIT] |=> chk_fault;
  endproperty
  a_xn_fetch: assert property (p_xn_fetch) else $error("fetch from XN region passed");

  c_region_hit: cover property (chk_valid && active && any_hit ##1 !chk_fault);
  c_overlap: cover property (chk_valid && region_hit[0] && region_hit[1]);
  c_valid_base_write: cover property (wr_take && reg_addr == OFS_BASE && reg_wdata[4]);
  c_attr_half: cover property (wr_take && reg_addr == OFS_ATTR && reg_byte_en == 4'hc);

endmodule

// file: tb/core_model.sv
// Purpose: Core load, store and fetch path issuing protection checks
// Assumes: One check per call, fields driven at the falling edge
// Notes: Released address lines show the inverse, never the last value
module core_model (
  input wire logic clock,
  output logic chk_valid,
  output logic [31:0] chk_addr,
  output logic chk_priv,
  output logic chk_write,
  output logic chk_fetch,
  output logic chk_vector,
  output logic chk_handler_neg,
  input wire logic chk_done,
  input wire logic chk_fault,
  input wire logic chk_strong,
  input wire logic [5:0] chk_mem_attr
);
  timeunit 1ns;
  timeprecision 1ns;
  // ****************************************
  // Check requests
  // ****************************************
  initial begin
    chk_valid = 1'b0;
    chk_addr = 32'h0;
    {chk_priv, chk_write, chk_fetch, chk_vector, chk_handler_neg} = 5'h00;
  end
  // Kind {priv, write, fetch, vector, handler}; result {done, fault, strong, attr}
  task automatic access(input logic [31:0] a, input logic [4:0] k, output logic [8:0] r);
    @(negedge clock);
    chk_valid = 1'b1;
    chk_addr = a;
    {chk_priv, chk_write, chk_fetch, chk_vector, chk_handler_neg} = k;
    @(negedge clock);
    r = {chk_done, chk_fault, chk_strong, chk_mem_attr};
    chk_valid = 1'b0;
    chk_addr = ~a;
  endtask
endmodule

// file: tb/tb.sv
// Purpose: Self-checking bench for the protection register block
// Assumes: Inputs change at the falling edge only
// Notes: Waits are bounded; a spent bound ends the run as a failure
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin num_errors++; \
  $display("MISMATCH %s expected %h seen %h", nm, e, g); end end
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import mpu_regs_pkg::*;
  logic clock, rst, reg_valid, reg_write, reg_ready, reg_rvalid;
  logic [7:0] reg_addr;
  logic [3:0] reg_byte_en;
  logic [31:0] reg_wdata, reg_rdata, chk_addr;
  logic chk_valid, chk_priv, chk_write, chk_fetch, chk_vector, chk_handler_neg;
  logic chk_done, chk_fault, chk_strong;
  logic [5:0] chk_mem_attr;
  int num_errors = 0;
  int tests_run = 0;
  // Fault mask {priv rd, priv wr, user rd, user wr} per permission code
  logic [3:0] ap_fault [8] = '{4'hf, 4'h3, 4'h1, 4'h0, 4'hf, 4'h7, 4'h5, 4'h5};

  memory_protection_unit_regs dut (.clock(clock), .rst(rst), .reg_valid(reg_valid),
    .reg_write(reg_write), .reg_addr(reg_addr), .reg_byte_en(reg_byte_en),
    .reg_wdata(reg_wdata), .reg_ready(reg_ready), .reg_rvalid(reg_rvalid),
    .reg_rdata(reg_rdata), .chk_valid(chk_valid), .chk_addr(chk_addr),
    .chk_priv(chk_priv), .chk_write(chk_write), .chk_fetch(chk_fetch),
    .chk_vector(chk_vector), .chk_handler_neg(chk_handler_neg), .chk_done(chk_done),
    .chk_fault(chk_fault), .chk_strong(chk_strong), .chk_mem_attr(chk_mem_attr));
  core_model core (.clock(clock), .chk_valid(chk_valid), .chk_addr(chk_addr),
    .chk_priv(chk_priv), .chk_write(chk_write), .chk_fetch(chk_fetch),
    .chk_vector(chk_vector), .chk_handler_neg(chk_handler_neg), .chk_done(chk_done),
    .chk_fault(chk_fault), .chk_strong(chk_strong), .chk_mem_attr(chk_mem_attr));

  // ****************************************
  // Register access and check tasks
  // ****************************************
  task automatic end_of_test;
    $display("Comparisons %0d, mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Request held from falling edge until the edge that samples ready high
  task automatic reg_op(input logic w, input logic [7:0] a, input logic [31:0] d,
                        input logic [3:0] be, output logic [31:0] q);
    int n;
    @(negedge clock);
    {reg_valid, reg_write, reg_addr, reg_wdata, reg_byte_en} = {1'b1, w, a, d, be};
    n = 0;
    while (reg_ready !== 1'b1 && n < 8) begin
      @(negedge clock);
      n++;
    end
    if (n >= 8) begin
      num_errors++;
      end_of_test;
    end
    @(negedge clock);
    {reg_valid, reg_addr, reg_wdata} = {1'b0, ~a, ~d};
    n = 0;
    while (!w && reg_rvalid !== 1'b1 && n < 4) begin
      @(negedge clock);
      n++;
    end
    if (n >= 4) begin
      num_errors++;
      end_of_test;
    end
    q = reg_rdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] be = 4'hf);
    logic [31:0] q;
    reg_op(1'b1, a, d, be, q);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    reg_op(1'b0, a, 32'h0, 4'hf, q);
    `CHK("reg_rdata", e, q)
  endtask

  task automatic acc(input logic [31:0] a, input logic [4:0] k, input logic ef,
                     input logic es, input logic [5:0] ea);
    logic [8:0] r;
    core.access(a, k, r);
    `CHK("chk_done", 1'b1, r[8])
    `CHK("chk_fault", ef, r[7])
    `CHK("chk_strong", es, r[6])
    if (!ef) `CHK("chk_mem_attr", ea, r[5:0])
  endtask

  // ****************************************
  // Sequence
  // ****************************************
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  initial begin
    static logic [7:0] offs [5] = '{OFS_CONTROL, OFS_SELECT, OFS_BASE, OFS_ATTR, 8'h00};
    rst = 1'b1;
    {reg_valid, reg_write, reg_addr, reg_byte_en, reg_wdata} = '0;
    repeat (3) @(negedge clock);
    rst = 1'b0;
    foreach (offs[i]) rd_chk(offs[i], 32'h0);
    wr(8'h14, 32'hffffffff);
    rd_chk(8'h14, 32'h0);
    wr(OFS_BASE, 32'h20000011);
    rd_chk(OFS_SELECT, 32'h1);
    rd_chk(OFS_BASE, 32'h20000001);
    // Reserved bits 23:22 and 7:6 written as ones must read back zero
    wr(OFS_ATTR, 32'h13cd00d3);
    rd_chk(OFS_ATTR, 32'h130d0013);
    wr(OFS_SELECT, 32'h2);
    wr(OFS_BASE, 32'h30000005);
    rd_chk(OFS_SELECT, 32'h2);
    rd_chk(OFS_BASE, 32'h30000002);
    wr(OFS_ATTR, 32'h03000000, 4'hc);
    wr(OFS_ATTR, 32'h0000020f, 4'h3);
    rd_chk(OFS_ATTR, 32'h0300020f);
    wr(OFS_CONTROL, 32'h5);
    acc(32'h40000000, 5'b10000, 1'b0, 1'b0, 6'h00);
    acc(32'h40000000, 5'b00000, 1'b1, 1'b0, 6'h00);
    acc(32'h20000010, 5'b00000, 1'b0, 1'b0, 6'h0d);
    acc(32'h20000010, 5'b10100, 1'b1, 1'b0, 6'h00);
    acc(32'h30000024, 5'b00000, 1'b1, 1'b0, 6'h00);
    acc(32'h300000e4, 5'b00000, 1'b0, 1'b0, 6'h00);
    acc(32'h30000100, 5'b00000, 1'b1, 1'b0, 6'h00);
    wr(OFS_CONTROL, 32'h1);
    acc(32'h40000000, 5'b10000, 1'b1, 1'b0, 6'h00);
    acc(32'h40000000, 5'b00010, 1'b0, 1'b0, 6'h00);
    acc(32'he000e100, 5'b00000, 1'b0, 1'b1, 6'h00);
    acc(32'he000e100, 5'b10100, 1'b1, 1'b1, 6'h00);
    acc(32'h40000000, 5'b10001, 1'b0, 1'b0, 6'h00);
    wr(OFS_CONTROL, 32'h3);
    acc(32'h40000000, 5'b10001, 1'b1, 1'b0, 6'h00);
    wr(OFS_SELECT, 32'h1);
    for (int i = 0; i < 8; i++) begin
      wr(OFS_ATTR, {5'h00, 3'(i), 8'h0d, 16'h0000}, 4'hc);
      for (int j = 0; j < 4; j++) begin
        acc(32'h20000010, {!j[1], j[0], 3'b000}, ap_fault[i][3-j], 1'b0, 6'h0d);
      end
    end
    // Higher region 3 overlaps the read-only region 1 start
    wr(OFS_BASE, 32'h20000013);
    wr(OFS_ATTR, 32'h03000009);
    acc(32'h20000004, 5'b01000, 1'b0, 1'b0, 6'h00);
    acc(32'h20000024, 5'b01000, 1'b1, 1'b0, 6'h00);
    wr(OFS_BASE, 32'h00000014);
    wr(OFS_ATTR, 32'h0200003f);
    acc(32'h90000000, 5'b01000, 1'b1, 1'b0, 6'h00);
    acc(32'h90000000, 5'b00000, 1'b0, 1'b0, 6'h00);
    wr(OFS_CONTROL, 32'h4);
    acc(32'h90000000, 5'b01000, 1'b0, 1'b0, 6'h00);
    acc(32'he000e100, 5'b10100, 1'b1, 1'b1, 6'h00);
    end_of_test;
  end
endmodule
